//--- rtl/dac_ctrl_map.vh
// Register map, field positions and timing constants of the output control block
`ifndef DAC_CTRL_MAP_VH
`define DAC_CTRL_MAP_VH

// Register indices on the Avalon-MM slave (one register per word address)
`define OFS_CONTROL      4'h0
`define OFS_DATA         4'h1
`define OFS_STATUS       4'h2
`define OFS_COMMAND      4'h3
`define OFS_OUTPUT       4'h4

// Serial control words that select the same registers
`define CW_CONTROL       8'h55
`define CW_DATA          8'h01

// Configuration register fields
`define CF_CLEAR_LEVEL   15
`define CF_RANGE_EXTEND  14
`define CF_EXT_SENSE     13
`define CF_OUTPUT_ON     12
`define CF_RATE_HI       11
`define CF_RATE_LO       8
`define CF_STEP_HI       7
`define CF_STEP_LO       5
`define CF_RAMP_ON       4
`define CF_CHAIN_ON      3
`define CF_RANGE_HI      2
`define CF_RANGE_LO      0

// Data register: code in the top twelve bits
`define DT_CODE_HI       15
`define DT_CODE_LO       4

// Status register fields
`define ST_LOOP_OPEN     4'h5
`define ST_RAMP_BUSY     4'h4
`define ST_OVER_TEMP     4'h3
`define ST_LINE_LOW      4'h6

// Command register fields
`define CM_CLEAR         4'h0
`define CM_RESET         4'h1

// Output codes
`define CODE_ZERO        12'h000
`define CODE_MID         12'h800

// Range encodings
`define RANGE_BIPOLAR_A  3'h2
`define RANGE_BIPOLAR_B  3'h3
`define RANGE_CURRENT    2

// Timing
`define CLK_HZ           32'h05f5e100
`define RATE_F0          32'h000186a0
`define RATE_F1          32'h0007a120
`define RATE_F2          32'h00051615
`define RATE_F3          32'h0003d090
`define RATE_F4          32'h00030d40
`define RATE_F5          32'h000186a0
`define RATE_F6          32'h0000c350
`define RATE_F7          32'h00008235
`define RATE_F8          32'h000061a8
`define RATE_F9          32'h00004e20
`define RATE_F10         32'h000030d4
`define RATE_F11         32'h00002710
`define RATE_F12         32'h0000208d
`define RATE_F13         32'h00001a0a
`define RATE_F14         32'h00001388
`define RATE_F15         32'h00000f51
`define DIV_W            15

`endif

//--- rtl/dac_output_slew_clear_fault_control.v
// Output code control: fault alert, clear, range bits and digital slew ramp
//
// Contract
// - Open-drain alert driven active while any fault condition is present.
// - Alert raised on low current-loop drive headroom, before any output error.
// - Alert raised when core temperature passes about 150 degrees C.
// - Separate status flags show loop-open and over-temperature causes.
// - Clear input active high, forces clear value regardless of bus traffic.
// - Effective clear level is OR of clear-level pin and register bit.
// - Level 0 clears to 0 V; level 1 to mid-scale or negative full-scale.
// - Current ranges clear to the lowest value of the range.
// - Output stays at cleared value until new data is written.
// - Clear command from registers loads the clear value like the clear pin, for one cycle only.
// - Range-extend bit widens the voltage range by ten percent.
// - Register bit selects external sense resistor for current output.
// - With ramp off, new codes apply directly on both outputs.
// - With ramp on, output steps toward target once per update tick.
// - Four-bit rate field picks tick rate from sixteen-entry table.
// - Three-bit step field gives step of two to the field power LSBs.
// - With ramp on every change ramps, clear included.
// - Configuration write during a ramp halts output at present value.
// - Control word 0x55 and layout of configuration register bits.
// - Ramp-busy flag at status bit four while output is ramping.
// - Control word 0x01 data register, code in top twelve bits.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`include "dac_ctrl_map.vh"

module dac_output_slew_clear_fault_control (
   input  wire        mclk,
   input  wire        arst_n,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [3:0]  byteenable,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Pins
   input  wire        clear_in,
   input  wire        clear_level_in,
   input  wire        loop_headroom_low,
   input  wire        over_temp_in,
   input  wire        fault_pin_in,
   output wire        fault_pin_out,
   output wire        fault_pin_oe_n,
   // Converter controls
   output reg  [11:0] dac_code,
   output wire [2:0]  range_sel,
   output wire        range_extend_bit,
   output wire        ext_sense_resistor_bit,
   output wire        output_on_bit,
   output wire        chain_on_bit
);

   reg  [15:0]        config_q;
   reg  [11:0]        target_q;
   reg  [`DIV_W-1:0]  tick_cnt_q;
   reg                ack_q;
   reg  [1:0]         clr_sync_q;
   reg  [1:0]         lvl_sync_q;
   reg  [1:0]         loop_sync_q;
   reg  [1:0]         temp_sync_q;
   reg  [1:0]         line_sync_q;

   wire               req;
   wire               take;
   wire               wr_ctrl;
   wire               wr_data;
   wire               wr_cmd;
   wire               clear_lvl;
   wire               clear_hold;
   wire               clear_go;
   wire [11:0]        clear_val;
   wire               ramp_on;
   wire               busy;
   wire               tick;
   wire [15:0]        status_w;
   wire [15:0]        ctrl_merged;
   wire [11:0]        data_merged;
   wire [15:0]        data_lanes;
   wire               soft_rst;
   wire               cmd_clear;
   wire [3:0]         rate_sel;
   wire [2:0]         step_sel;
   wire [`DIV_W-1:0]  one_div;
   wire [`DIV_W-1:0]  period_m1;
   wire [11:0]        ramp_target;
   wire [11:0]        ramp_next;
   wire [11:0]        direct_next;
   wire               step_go;

   // Update period in clock cycles for a rate code
   function [`DIV_W-1:0] rate_div;
      input [3:0] code;
      reg   [31:0] f;
      reg   [31:0] q;
      begin
         case (code)
            4'h0:    f = `RATE_F0;
            4'h1:    f = `RATE_F1;
            4'h2:    f = `RATE_F2;
            4'h3:    f = `RATE_F3;
            4'h4:    f = `RATE_F4;
            4'h5:    f = `RATE_F5;
            4'h6:    f = `RATE_F6;
            4'h7:    f = `RATE_F7;
            4'h8:    f = `RATE_F8;
            4'h9:    f = `RATE_F9;
            4'ha:    f = `RATE_F10;
            4'hb:    f = `RATE_F11;
            4'hc:    f = `RATE_F12;
            4'hd:    f = `RATE_F13;
            4'he:    f = `RATE_F14;
            default: f = `RATE_F15;
         endcase
         q = `CLK_HZ / f;
         rate_div = q[`DIV_W-1:0];
      end
   endfunction

   // Clear code for the active range and level
   function [11:0] clear_code;
      input [2:0] range;
      input       level;
      begin
         if (range[`RANGE_CURRENT]) begin
            clear_code = `CODE_ZERO;
         end else if (range == `RANGE_BIPOLAR_A || range == `RANGE_BIPOLAR_B) begin
            clear_code = level ? `CODE_ZERO : `CODE_MID;
         end else begin
            clear_code = level ? `CODE_MID : `CODE_ZERO;
         end
      end
   endfunction

   // One ramp step toward the target, clipped so it never overshoots
   function [11:0] step_toward;
      input [11:0] cur;
      input [11:0] tgt;
      input [2:0]  sel;
      reg   [11:0] inc;
      begin
         inc = 12'h001 << sel;
         if (tgt > cur) begin
            step_toward = (tgt - cur < inc) ? tgt : cur + inc;
         end else if (tgt < cur) begin
            step_toward = (cur - tgt < inc) ? tgt : cur - inc;
         end else begin
            step_toward = cur;
         end
      end
   endfunction

   // Byte-lane merge of a 16-bit register
   function [15:0] lane_merge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  be;
      begin
         lane_merge[7:0]  = be[0] ? nw[7:0]  : old[7:0];
         lane_merge[15:8] = be[1] ? nw[15:8] : old[15:8];
      end
   endfunction

   // One command bit of a taken command write
   function cmd_hit;
      input        hit;
      input        lane;
      input [15:0] wd;
      input [3:0]  pos;
      begin
         cmd_hit = hit & lane & wd[pos];
      end
   endfunction

   // One flag placed at its status bit
   function [15:0] flag_at;
      input       v;
      input [3:0] pos;
      begin
         flag_at = {15'h0000, v} << pos;
      end
   endfunction

   // Read word for a register index; unmapped indices read as zero
   function [31:0] read_word;
      input [3:0]  idx;
      input [15:0] cfg;
      input [11:0] tgt;
      input [15:0] st;
      input [11:0] code;
      begin
         case (idx)
            `OFS_CONTROL: read_word = {16'h0000, cfg};
            `OFS_DATA:    read_word = {16'h0000, tgt, 4'h0};
            `OFS_STATUS:  read_word = {16'h0000, st};
            `OFS_OUTPUT:  read_word = {20'h00000, code};
            default:      read_word = 32'h00000000;
         endcase
      end
   endfunction

   // Bus slave: every access answers at the second edge.
   // Exactly one wait cycle: the acknowledge flop rises after the first edge
   // and falls after the second, so back-to-back requests each get a wait.
   assign req         = read | write;
   assign take        = req & ack_q;
   assign waitrequest = req & ~ack_q;
   assign wr_ctrl     = take & write & (address == `OFS_CONTROL);
   assign wr_data     = take & write & (address == `OFS_DATA);
   assign wr_cmd      = take & write & (address == `OFS_COMMAND);

   assign ctrl_merged = lane_merge(config_q, writedata[15:0], byteenable[1:0]);
   assign data_lanes  = lane_merge({target_q, 4'h0}, writedata[15:0],
                                   byteenable[1:0]);
   assign data_merged = data_lanes[`DT_CODE_HI:`DT_CODE_LO];

   // Configuration fields
   assign clear_lvl   = clear_lvl_pin_or_bit(lvl_sync_q[1], config_q[`CF_CLEAR_LEVEL]);
   assign ramp_on     = config_q[`CF_RAMP_ON];
   assign range_sel   = config_q[`CF_RANGE_HI:`CF_RANGE_LO];
   assign range_extend_bit       = config_q[`CF_RANGE_EXTEND];
   assign ext_sense_resistor_bit = config_q[`CF_EXT_SENSE];
   assign output_on_bit          = config_q[`CF_OUTPUT_ON];
   assign chain_on_bit           = config_q[`CF_CHAIN_ON];

   function clear_lvl_pin_or_bit;
      input a;
      input b;
      begin
         clear_lvl_pin_or_bit = a | b;
      end
   endfunction

   // Clear: held while the pin is high, and once on a command
   assign clear_val  = clear_code(range_sel, clear_lvl);
   assign clear_hold = clr_sync_q[1];
   assign cmd_clear  = cmd_hit(wr_cmd, byteenable[0], writedata[15:0], `CM_CLEAR);
   assign soft_rst   = cmd_hit(wr_cmd, byteenable[0], writedata[15:0], `CM_RESET);
   assign clear_go   = clear_hold | cmd_clear;

   assign busy = ramp_on & (dac_code != target_q);
   assign tick = (tick_cnt_q == {`DIV_W{1'b0}});

   // Ramp step and direct update values; a clear steers the ramp at once
   assign rate_sel    = config_q[`CF_RATE_HI:`CF_RATE_LO];
   assign step_sel    = config_q[`CF_STEP_HI:`CF_STEP_LO];
   assign one_div     = {{(`DIV_W-1){1'b0}}, 1'b1};
   assign period_m1   = rate_div(rate_sel) - one_div;
   assign ramp_target = clear_go ? clear_val : target_q;
   assign ramp_next   = step_toward(dac_code, ramp_target, step_sel);
   assign step_go     = tick & busy & (clear_go | ~(wr_ctrl | wr_data));
   assign direct_next = clear_go ? clear_val : (wr_data ? data_merged : target_q);

   // Fault alert: open drain, pulled low while any fault is present
   assign fault_pin_out  = 1'b0;
   assign fault_pin_oe_n = ~(loop_sync_q[1] | temp_sync_q[1]);

   // Fault flags are live levels, not sticky
   assign status_w = flag_at(loop_sync_q[1], `ST_LOOP_OPEN)
                   | flag_at(temp_sync_q[1], `ST_OVER_TEMP)
                   | flag_at(busy, `ST_RAMP_BUSY)
                   | flag_at(~line_sync_q[1], `ST_LINE_LOW);

   // Clear pins: two flops before any logic reads them
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         clr_sync_q  <= 2'h0;
         lvl_sync_q  <= 2'h0;
      end else begin
         clr_sync_q  <= {clr_sync_q[0], clear_in};
         lvl_sync_q  <= {lvl_sync_q[0], clear_level_in};
      end
   end

   // Fault inputs and the shared alert wire, which idles high on its pull-up
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loop_sync_q <= 2'h0;
         temp_sync_q <= 2'h0;
         line_sync_q <= 2'h3;
      end else begin
         loop_sync_q <= {loop_sync_q[0], loop_headroom_low};
         temp_sync_q <= {temp_sync_q[0], over_temp_in};
         line_sync_q <= {line_sync_q[0], fault_pin_in};
      end
   end

   // Bus acknowledge and read data
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q    <= 1'b0;
         readdata <= 32'h00000000;
      end else begin
         ack_q <= req & ~ack_q;
         // Loaded at the first edge so it stands at the edge the master samples
         if (read & ~ack_q) begin
            readdata <= read_word(address, config_q, target_q, status_w, dac_code);
         end
      end
   end

   // Configuration register
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         config_q <= 16'h0000;
      end else if (soft_rst) begin
         config_q <= 16'h0000;
      end else if (wr_ctrl) begin
         config_q <= ctrl_merged;
      end
   end

   // Ramp timer: held at a full period while idle, so a new target waits one period
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_q <= {`DIV_W{1'b0}};
      end else if (soft_rst) begin
         tick_cnt_q <= {`DIV_W{1'b0}};
      end else if (tick | ~busy) begin
         tick_cnt_q <= period_m1;
      end else begin
         tick_cnt_q <= tick_cnt_q - one_div;
      end
   end

   // Target code: a clear beats a data write in the same cycle
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         target_q <= `CODE_ZERO;
      end else if (soft_rst) begin
         target_q <= `CODE_ZERO;
      end else if (clear_go) begin
         target_q <= clear_val;
      end else if (wr_ctrl & busy) begin
         // Halting a ramp freezes the output where it stands
         target_q <= dac_code;
      end else if (wr_data) begin
         target_q <= data_merged;
      end
   end

   // Output code: direct with the ramp off, one clipped step per tick with it on
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dac_code <= `CODE_ZERO;
      end else if (soft_rst) begin
         dac_code <= `CODE_ZERO;
      end else if (!ramp_on) begin
         dac_code <= direct_next;
      end else if (step_go) begin
         dac_code <= ramp_next;
      end
   end

endmodule

//--- verification/dac_ctrl_sva.sv
// Concurrent checks on the ports of the output control block
module dac_ctrl_sva (
   input logic        mclk,
   input logic        arst_n,
   input logic [3:0]  address,
   input logic        read,
   input logic        write,
   input logic [3:0]  byteenable,
   input logic [31:0] writedata,
   input logic [31:0] readdata,
   input logic        waitrequest,
   input logic        loop_headroom_low,
   input logic        over_temp_in,
   input logic        fault_pin_out,
   input logic        fault_pin_oe_n,
   input logic [2:0]  range_sel,
   input logic        range_extend_bit,
   input logic        ext_sense_resistor_bit,
   input logic        output_on_bit,
   input logic        chain_on_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire [6:0]   cfg  = {range_extend_bit, ext_sense_resistor_bit, output_on_bit,
                        chain_on_bit, range_sel};
   wire         took = write & ~waitrequest;
   logic [31:0] wd_q;
   always @(posedge mclk) begin
      wd_q <= writedata;
   end
   sequence fault_held;
      (loop_headroom_low || over_temp_in) [*4];
   endsequence
   sequence calm_held;
      (!loop_headroom_low && !over_temp_in) [*4];
   endsequence
   sequence wr_taken(logic [3:0] a);
      write && !waitrequest && address == a && byteenable == 4'hf;
   endsequence
   a_alert_driven: assert property (fault_held |-> !fault_pin_oe_n)
      else $error("alert not driven during fault");
   a_alert_free: assert property (calm_held |-> fault_pin_oe_n)
      else $error("alert driven without fault");
   a_alert_low_only: assert property (fault_pin_out == 1'b0)
      else $error("alert wire driven high");
   a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait");
   a_idle_ready: assert property (!(read || write) |-> !waitrequest)
      else $error("wait raised while idle");
   a_cfg_load: assert property (wr_taken(4'h0)
      |=> cfg == {wd_q[14:12], wd_q[3:0]})
      else $error("config outputs do not follow write");
   a_cfg_steady: assert property ($changed(cfg) |-> $past(took))
      else $error("config outputs moved without write");
   a_unmapped_zero: assert property (read && !waitrequest && address > 4'h4
      |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_status_spare: assert property (read && !waitrequest && address == 4'h2
      |-> readdata[31:7] == 25'h0 && readdata[2:0] == 3'h0)
      else $error("status spare bits set");
endmodule

bind dac_output_slew_clear_fault_control dac_ctrl_sva i_sva (
   .mclk(mclk), .arst_n(arst_n), .address(address), .read(read), .write(write),
   .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .loop_headroom_low(loop_headroom_low),
   .over_temp_in(over_temp_in), .fault_pin_out(fault_pin_out),
   .fault_pin_oe_n(fault_pin_oe_n), .range_sel(range_sel),
   .range_extend_bit(range_extend_bit), .ext_sense_resistor_bit(ext_sense_resistor_bit),
   .output_on_bit(output_on_bit), .chain_on_bit(chain_on_bit));

//--- verification/host_bus_model.sv
// Host controller model reaching the registers over Avalon-MM
module host_bus_model (
   input  logic        mclk,
   input  logic        waitrequest,
   input  logic [31:0] readdata,
   output logic [3:0]  address = 4'h0,
   output logic        read = 1'b0,
   output logic        write = 1'b0,
   output logic [3:0]  byteenable = 4'h0,
   output logic [31:0] writedata = 32'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic xfer(input logic [3:0] a, input logic wr, input logic [15:0] d,
                       output logic [31:0] q);
      @(posedge mclk);
      address <= a;
      writedata <= {16'h0, d};
      byteenable <= 4'hf;
      write <= wr;
      read <= !wr;
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      writedata <= ~writedata;
      @(negedge mclk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 16'h0, q);
   endtask
   task automatic wait_idle;
      logic [31:0] q;
      do xfer(4'h2, 1'b0, 16'h0, q); while (q[4] !== 1'b0);
   endtask
endmodule

//--- verification/dac_output_slew_clear_fault_control_tb.sv
// Self-checking bench for the output control block
module dac_output_slew_clear_fault_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic        clear_in = 1'b0;
   logic        clear_level_in = 1'b0;
   logic        loop_headroom_low = 1'b0;
   logic        over_temp_in = 1'b0;
   logic [3:0]  address, byteenable;
   logic        read, write, waitrequest, fault_pin_out, fault_pin_oe_n;
   logic [31:0] writedata, readdata, q;
   logic [31:0] seed = 32'h0699;
   logic [11:0] dac_code, v;
   logic [2:0]  range_sel, r;
   logic        range_extend_bit, ext_sense_resistor_bit, output_on_bit, chain_on_bit;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          n;
   // Shared alert wire with its pull-up
   wire         fault_pin_in = fault_pin_oe_n ? 1'b1 : fault_pin_out;

   always #5 mclk = ~mclk;

   dac_output_slew_clear_fault_control i_dut (
      .mclk(mclk), .arst_n(arst_n), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .clear_in(clear_in), .clear_level_in(clear_level_in),
      .loop_headroom_low(loop_headroom_low), .over_temp_in(over_temp_in),
      .fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
      .fault_pin_oe_n(fault_pin_oe_n), .dac_code(dac_code), .range_sel(range_sel),
      .range_extend_bit(range_extend_bit), .ext_sense_resistor_bit(ext_sense_resistor_bit),
      .output_on_bit(output_on_bit), .chain_on_bit(chain_on_bit));

   host_bus_model i_host (
      .mclk(mclk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [11:0] clr_code(input logic [2:0] rg, input logic lv);
      if (rg[2]) return 12'h000;
      return (rg[1] ^ lv) ? 12'h800 : 12'h000;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      chk("dac_code", dac_code, 32'h0);
      chk("alert_oe_n", fault_pin_oe_n, 32'h1);
      i_host.rd(4'h0, q);
      chk("control", q, 32'h0);
      i_host.rd(4'h7, q);
      chk("unmapped", q, 32'h0);
      repeat (8) begin
         seed = lfsr(seed);
         i_host.wr(4'h0, seed[15:0] & 16'hffef);
         chk("cfg_pins", cfg_view(), {seed[14:12], seed[3:0]});
         i_host.rd(4'h0, q);
         chk("control", q, {16'h0, seed[15:0] & 16'hffef});
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         loop_headroom_low <= i[0];
         over_temp_in <= i[1];
         repeat (5) @(negedge mclk);
         chk("alert_oe_n", fault_pin_oe_n, !(i[0] | i[1]));
         i_host.rd(4'h2, q);
         chk("status", q[6:3], {i[0] | i[1], i[0], 1'b0, i[1]});
      end
      repeat (12) begin
         seed = lfsr(seed);
         r = (seed[2:0] == 3'h4) ? 3'h5 : seed[2:0];
         i_host.wr(4'h0, {seed[4], 12'h0, r});
         i_host.wr(4'h1, 16'h5a5f);
         chk("direct", dac_code, 32'h5a5);
         i_host.rd(4'h1, q);
         chk("data", q, 32'h5a50);
         @(posedge mclk);
         clear_level_in <= seed[3];
         if (seed[5]) i_host.wr(4'h3, 16'h0001);
         else begin
            clear_in <= 1'b1;
            repeat (4) @(posedge mclk);
            clear_in <= 1'b0;
         end
         repeat (8) @(negedge mclk);
         chk("cleared", dac_code, clr_code(r, seed[3] | seed[4]));
      end
      i_host.wr(4'h0, 16'h0000);
      i_host.wr(4'h1, 16'h0000);
      i_host.wr(4'h0, 16'h00f0);
      i_host.wr(4'h1, 16'h1500);
      i_host.rd(4'h2, q);
      chk("ramp_busy", q[4], 32'h1);
      v = 12'h0;
      for (int k = 1; k <= 3; k++) begin
         n = 0;
         while (dac_code === v) begin
            @(negedge mclk);
            n++;
         end
         v = dac_code;
         chk("ramp_step", v, (k == 3) ? 32'h150 : k * 128);
      end
      chk("tick_gap", n, 32'd1000);
      i_host.wait_idle();
      i_host.wr(4'h1, 16'h0000);
      repeat (1500) @(negedge mclk);
      i_host.wr(4'h0, 16'h00f0);
      v = dac_code;
      chk("moved", v < 12'h150, 32'h1);
      repeat (3000) @(negedge mclk);
      chk("halted", dac_code, v);
      @(posedge mclk);
      clear_in <= 1'b1;
      repeat (4) @(posedge mclk);
      clear_in <= 1'b0;
      repeat (8) @(negedge mclk);
      chk("clear_ramps", dac_code, v);
      tally_and_finish();
   end

   function automatic logic [6:0] cfg_view;
      return {range_extend_bit, ext_sense_resistor_bit, output_on_bit, chain_on_bit,
              range_sel};
   endfunction
endmodule
